// File: common/gei_pkg.sv
// Shared constants, register map and types of the GPIO and edge interrupt block.
package gei_pkg;

    // ----------------
    // Sizes
    // ----------------
    localparam int NPIN     = 16;
    localparam int NLINE    = 24;
    localparam int NPINLINE = 16;
    localparam int NSRC     = 8;
    localparam int NEXT     = 115;
    localparam int NAF      = 4;
    localparam int NTIM     = 3;
    localparam int SELW     = 7;
    localparam int AFW      = 2;
    localparam int TSW      = 4;
    localparam int PULLW    = 2;
    localparam int REMAPW   = 8;
    localparam int SELFLD   = 8;
    localparam int SELPERW  = 4;

    // ----------------
    // Register byte offsets
    // ----------------
    localparam logic [11:0] ADDR_DIR      = 12'h000;
    localparam logic [11:0] ADDR_OTYPE    = 12'h004;
    localparam logic [11:0] ADDR_PULL     = 12'h008;
    localparam logic [11:0] ADDR_ODATA    = 12'h00c;
    localparam logic [11:0] ADDR_IDATA    = 12'h010;
    localparam logic [11:0] ADDR_AFSEL    = 12'h014;
    localparam logic [11:0] ADDR_AFMAP    = 12'h018;
    localparam logic [11:0] ADDR_LOCK     = 12'h01c;
    localparam logic [11:0] ADDR_SYSREMAP = 12'h020;
    localparam logic [11:0] ADDR_TIMSEL   = 12'h024;
    localparam logic [11:0] ADDR_RISE     = 12'h028;
    localparam logic [11:0] ADDR_FALL     = 12'h02c;
    localparam logic [11:0] ADDR_IMASK    = 12'h030;
    localparam logic [11:0] ADDR_EMASK    = 12'h034;
    localparam logic [11:0] ADDR_PEND     = 12'h038;
    localparam logic [11:0] ADDR_SETCLR   = 12'h03c;
    localparam logic [11:0] ADDR_LINESEL  = 12'h040;

    // ----------------
    // Field encodings, keys and reset values
    // ----------------
    localparam logic [1:0]  PULL_NONE = 2'h0;
    localparam logic [1:0]  PULL_UP   = 2'h1;
    localparam logic [1:0]  PULL_DOWN = 2'h2;
    localparam logic [31:0] LOCK_KEY1 = 32'h0000_5a5a;
    localparam logic [31:0] LOCK_KEY2 = 32'h0000_a5a5;
    localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
    localparam int          LOCK_BIT  = 0;
    localparam int          HALF      = 16;

    typedef enum logic [1:0] {
        LK_OPEN,
        LK_KEY1,
        LK_LOCKED
    } gei_lock_type;

    // Everything that goes out to the pads of the port.
    typedef struct packed {
        logic [NPIN-1:0] out;
        logic [NPIN-1:0] oe;
        logic [NPIN-1:0] pull_up;
        logic [NPIN-1:0] pull_down;
    } gei_pad_type;

endpackage

// File: rtl/gei_sync.sv
// Two flip-flop level synchroniser for a vector of inputs.
`timescale 1ns/1ps
module gei_sync
    import gei_pkg::*;
#(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule

// File: rtl/gei_edge_cell.sv
// Edge catcher for one interrupt line, including pulses shorter than pclk.
`timescale 1ns/1ps
module gei_edge_cell
    import gei_pkg::*;
(
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Asynchronous line
    input  wire logic line_in,
    // Detected edges, one pclk cycle each
    output logic      rise_evt,
    output logic      fall_evt
);

    logic       rise_tgl_r;
    logic       fall_tgl_r;
    logic [1:0] tgl_sync;
    logic [1:0] tgl_prev_r;

    // The line itself clocks a toggle, so a pulse far narrower than one
    // pclk period still leaves a lasting change to be synchronised.
    always_ff @(posedge line_in or negedge presetn) begin // see [R10]
        if (!presetn) begin
            rise_tgl_r <= 1'b0;
        end else begin
            rise_tgl_r <= ~rise_tgl_r;
        end
    end

    always_ff @(negedge line_in or negedge presetn) begin // see [R10]
        if (!presetn) begin
            fall_tgl_r <= 1'b0;
        end else begin
            fall_tgl_r <= ~fall_tgl_r;
        end
    end

    gei_sync #(.W(2)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({fall_tgl_r, rise_tgl_r}),
        .q       (tgl_sync)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tgl_prev_r <= 2'h0;
        end else begin
            tgl_prev_r <= tgl_sync;
        end
    end

    assign rise_evt = tgl_sync[0] ^ tgl_prev_r[0];
    assign fall_evt = tgl_sync[1] ^ tgl_prev_r[1];

endmodule

// File: rtl/gei_top.sv
// GPIO port with alternate-function routing, lock and edge interrupt lines.
//
// Summary of operation
// [R1] Output pins drive push-pull or open-drain.
// [R2] Input pins take pull-up, pull-down or none.
// [R3] Pins pass to remappable alternate functions.
// [R4] Key sequence locks alternate-function setup.
// [R5] Port on fast bus, toggles beyond 16 MHz.
// [R6] Twenty-four edge lines raise interrupts or events.
// [R7] Each line triggers rising, falling or both.
// [R8] Each line masked on its own.
// [R9] Readable per-line pending status.
// [R10] Pulses shorter than pclk are still caught.
// [R11] Sixteen lines select any of 115 pins.
// [R12] Eight lines come from on-chip sources.
// [R13] System remap moves functions between ports.
// [R14] Pins routed to three timer capture inputs.
// [R15] Unmasked edge sets pending, holds interrupt.
// [R16] Writing one clears pending; zero keeps it.
`timescale 1ns/1ps
module gei_top
    import gei_pkg::*;
(
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // Port pads
    input  wire logic [NPIN-1:0]     pad_in,
    output gei_pad_type              pad,
    // Alternate functions
    input  wire logic [NAF-1:0]      af_out,
    input  wire logic [NAF-1:0]      af_oe,
    output logic      [NPIN-1:0]     af_in,
    output logic      [REMAPW-1:0]   sys_remap,
    output logic      [NTIM-1:0]     tim_capture,
    // Interrupt line sources
    input  wire logic [NEXT-1:0]     ext_pins,
    input  wire logic [NSRC-1:0]     onchip_src,
    // Requests
    output logic                     irq,
    output logic      [NLINE-1:0]    event_req
);

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    function automatic logic is_linesel(input logic [11:0] a);
        is_linesel = (a[11:4] == ADDR_LINESEL[11:4]);
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = is_linesel(a) || (a[1:0] == 2'h0 && a <= ADDR_SETCLR);
    endfunction

    function automatic logic pick_pin(input logic [NEXT-1:0] pins,
                                      input logic [SELW-1:0] sel);
        pick_pin = (32'(sel) < NEXT) ? pins[sel] : 1'b0;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [NPIN-1:0]       dir_r;
    logic [NPIN-1:0]       otype_r;
    logic [2*NPIN-1:0]     pull_r;
    logic [NPIN-1:0]       odata_r;
    logic [NPIN-1:0]       afsel_r;
    logic [AFW*NPIN-1:0]   afmap_r;
    logic [REMAPW-1:0]     remap_r;
    logic [TSW*NTIM-1:0]   timsel_r;
    logic [NLINE-1:0]      rise_r;
    logic [NLINE-1:0]      fall_r;
    logic [NLINE-1:0]      imask_r;
    logic [NLINE-1:0]      emask_r;
    logic [NLINE-1:0]      pend_r;
    logic [NLINE-1:0]      pend_nxt;
    logic [SELW-1:0]       linesel_r [NPINLINE];
    gei_lock_type          lock_r;
    logic [31:0]           rdata_nxt;
    logic [NPIN-1:0]       pin_sync;
    logic [NLINE-1:0]      line_raw;
    logic [NLINE-1:0]      rise_evt;
    logic [NLINE-1:0]      fall_evt;
    logic [NLINE-1:0]      trig;
    logic                  wr;
    logic                  setup;
    logic                  locked;

    assign setup  = psel & ~penable;
    assign wr     = psel & penable & pwrite;
    assign locked = (lock_r == LK_LOCKED);

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle, so every transfer ends in
    // its first access cycle while prdata still comes from a flip-flop.
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~is_mapped(paddr);

    always_comb begin
        rdata_nxt = RST_ZERO;
        case (paddr)
            ADDR_DIR:      rdata_nxt[NPIN-1:0]     = dir_r;
            ADDR_OTYPE:    rdata_nxt[NPIN-1:0]     = otype_r;
            ADDR_PULL:     rdata_nxt               = pull_r;
            ADDR_ODATA:    rdata_nxt[NPIN-1:0]     = odata_r;
            ADDR_IDATA:    rdata_nxt[NPIN-1:0]     = pin_sync;
            ADDR_AFSEL:    rdata_nxt[NPIN-1:0]     = afsel_r;
            ADDR_AFMAP:    rdata_nxt               = afmap_r;
            ADDR_LOCK:     rdata_nxt[LOCK_BIT]     = locked;
            ADDR_SYSREMAP: rdata_nxt[REMAPW-1:0]   = remap_r;
            ADDR_TIMSEL:   rdata_nxt[TSW*NTIM-1:0] = timsel_r;
            ADDR_RISE:     rdata_nxt[NLINE-1:0]    = rise_r;
            ADDR_FALL:     rdata_nxt[NLINE-1:0]    = fall_r;
            ADDR_IMASK:    rdata_nxt[NLINE-1:0]    = imask_r;
            ADDR_EMASK:    rdata_nxt[NLINE-1:0]    = emask_r;
            ADDR_PEND:     rdata_nxt[NLINE-1:0]    = pend_r; // see [R9]
            default: begin
                if (is_linesel(paddr)) begin
                    for (int k = 0; k < SELPERW; k++) begin
                        rdata_nxt[k*SELFLD +: SELW] =
                            linesel_r[{paddr[3:2], 2'(k)}];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= RST_ZERO;
        end else if (setup && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Pin configuration
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r   <= '0;
            otype_r <= '0;
            pull_r  <= '0;
        end else if (wr) begin
            case (paddr)
                ADDR_DIR:   dir_r   <= pwdata[NPIN-1:0];  // see [R1]
                ADDR_OTYPE: otype_r <= pwdata[NPIN-1:0];  // see [R1]
                ADDR_PULL:  pull_r  <= pwdata;            // see [R2]
                default: begin
                end
            endcase
        end
    end

    // A single set/clear word moves any mix of pins in one transfer, so
    // two-cycle APB writes give 25 MHz toggling at the pins.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            odata_r <= '0;
        end else if (wr && paddr == ADDR_ODATA) begin
            odata_r <= pwdata[NPIN-1:0];
        end else if (wr && paddr == ADDR_SETCLR) begin // see [R5]
            odata_r <= (odata_r & ~pwdata[HALF +: NPIN]) | pwdata[NPIN-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Alternate functions and lock
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_r <= LK_OPEN;
        end else if (wr && paddr == ADDR_LOCK) begin
            case (lock_r)
                LK_OPEN:   lock_r <= (pwdata == LOCK_KEY1) ? LK_KEY1
                                                           : LK_OPEN;
                LK_KEY1:   lock_r <= (pwdata == LOCK_KEY2) ? LK_LOCKED
                                                           : LK_OPEN;
                LK_LOCKED: lock_r <= LK_LOCKED; // see [R4]
                default:   lock_r <= LK_OPEN;
            endcase
        end
    end

    // Once locked only a reset frees the setup; stray writes are dropped
    // without an error, and the lock state stays readable at ADDR_LOCK.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            afsel_r  <= '0;
            afmap_r  <= '0;
            remap_r  <= '0;
            timsel_r <= '0;
        end else if (wr && !locked) begin // see [R4]
            case (paddr)
                ADDR_AFSEL:    afsel_r  <= pwdata[NPIN-1:0]; // see [R3]
                ADDR_AFMAP:    afmap_r  <= pwdata;           // see [R3]
                ADDR_SYSREMAP: remap_r  <= pwdata[REMAPW-1:0]; // see [R13]
                ADDR_TIMSEL:   timsel_r <= pwdata[TSW*NTIM-1:0]; // see [R14]
                default: begin
                end
            endcase
        end
    end

    assign sys_remap = remap_r; // see [R13]

    // ------------------------------------------------------------------
    // Pads
    // ------------------------------------------------------------------
    gei_sync #(.W(NPIN)) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       (pad_in),
        .q       (pin_sync)
    );

    assign af_in = pin_sync; // see [R3]

    always_ff @(posedge pclk or negedge presetn) begin
        logic [AFW-1:0] f;
        logic           val;
        logic           en;
        if (!presetn) begin
            pad <= '0;
        end else begin
            for (int p = 0; p < NPIN; p++) begin
                f   = afmap_r[p*AFW +: AFW];
                val = afsel_r[p] ? af_out[f] : odata_r[p]; // see [R3]
                en  = afsel_r[p] ? af_oe[f] : dir_r[p];
                pad.out[p]       <= val;
                // Open drain only ever pulls low.
                pad.oe[p]        <= en & (~otype_r[p] | ~val); // see [R1]
                pad.pull_up[p]   <= ~en &
                    (pull_r[p*PULLW +: PULLW] == PULL_UP);   // see [R2]
                pad.pull_down[p] <= ~en &
                    (pull_r[p*PULLW +: PULLW] == PULL_DOWN); // see [R2]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tim_capture <= '0;
        end else begin
            for (int t = 0; t < NTIM; t++) begin
                tim_capture[t] <= pin_sync[timsel_r[t*TSW +: TSW]]; // see [R14]
            end
        end
    end

    // ------------------------------------------------------------------
    // Edge interrupt controller
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NPINLINE; i++) begin
                linesel_r[i] <= '0;
            end
        end else if (wr && is_linesel(paddr)) begin
            for (int k = 0; k < SELPERW; k++) begin
                linesel_r[{paddr[3:2], 2'(k)}] <=
                    pwdata[k*SELFLD +: SELW]; // see [R11]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_r  <= '0;
            fall_r  <= '0;
            imask_r <= '0;
            emask_r <= '0;
        end else if (wr) begin
            case (paddr)
                ADDR_RISE:  rise_r  <= pwdata[NLINE-1:0]; // see [R7]
                ADDR_FALL:  fall_r  <= pwdata[NLINE-1:0]; // see [R7]
                ADDR_IMASK: imask_r <= pwdata[NLINE-1:0]; // see [R8]
                ADDR_EMASK: emask_r <= pwdata[NLINE-1:0]; // see [R8]
                default: begin
                end
            endcase
        end
    end

    // The pin selector sits ahead of the edge catcher; changing it can
    // fake an edge, so mask the line while it is reprogrammed.
    genvar g;
    generate
        for (g = 0; g < NLINE; g++) begin : g_line
            if (g < NPINLINE) begin : g_pin
                assign line_raw[g] = pick_pin(ext_pins, linesel_r[g]); // see [R11]
            end else begin : g_src
                assign line_raw[g] = onchip_src[g-NPINLINE]; // see [R12]
            end
            gei_edge_cell u_edge ( // see [R6]
                .pclk     (pclk),
                .presetn  (presetn),
                .line_in  (line_raw[g]),
                .rise_evt (rise_evt[g]),
                .fall_evt (fall_evt[g])
            );
        end
    endgenerate

    assign trig = (rise_evt & rise_r) | (fall_evt & fall_r); // see [R7]

    always_comb begin
        pend_nxt = pend_r;
        if (wr && paddr == ADDR_PEND) begin
            pend_nxt = pend_r & ~pwdata[NLINE-1:0]; // see [R16]
        end
        pend_nxt = pend_nxt | (trig & imask_r); // see [R15]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_r    <= '0;
            irq       <= 1'b0;
            event_req <= '0;
        end else begin
            pend_r    <= pend_nxt;
            irq       <= |(pend_nxt & imask_r); // see [R15]
            event_req <= trig & emask_r; // see [R6]
        end
    end

endmodule

// File: dv/gei_monitor.sv
// Port checker of the GPIO and edge interrupt block.
`timescale 1ns/1ps
module gei_monitor
    import gei_pkg::*;
(
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Pads, lines and requests
    input wire gei_pad_type       pad,
    input wire logic [NSRC-1:0]   onchip_src,
    input wire logic              irq,
    input wire logic [NLINE-1:0]  event_req
);
    // ----------------
    // Helper logic
    // ----------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic            acc;
    logic            mapped;
    logic [NSRC-1:0] src_q;
    logic [3:0]      src_age;
    assign acc    = psel && penable;
    assign mapped = (paddr[11:4] == ADDR_LINESEL[11:4])
        || (paddr[1:0] == 2'h0 && paddr <= ADDR_SETCLR);
    // Age saturates so that a long quiet spell never wraps to a young age.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q   <= '0;
            src_age <= 4'hf;
        end else begin
            src_q   <= onchip_src;
            if (onchip_src != src_q) begin
                src_age <= 4'h0;
            end else if (src_age != 4'hf) begin
                src_age <= src_age + 4'h1;
            end
        end
    end
    // ----------------
    // Properties
    // ----------------
    a_zero_wait: assert property (acc |-> pready)
        else $error("wait state");
    a_unmapped_err: assert property (acc && !pwrite && !mapped |->
        pslverr && prdata == 32'h0)
        else $error("unmapped read kept");
    a_mapped_ok: assert property (acc && mapped |-> !pslverr)
        else $error("mapped refused");
    a_idle_quiet: assert property (!acc |-> !pslverr)
        else $error("idle error");
    a_rdata_hold: assert property (acc |=> $stable(prdata))
        else $error("read data moved");
    a_pull_excl: assert property (
        (((pad.pull_up | pad.pull_down) & pad.oe)
        | (pad.pull_up & pad.pull_down)) == '0)
        else $error("pull clash");
    a_line_source: assert property (
        event_req[NLINE-1:NPINLINE] != '0 |->
        src_age >= 4'h1 && src_age <= 4'h6)
        else $error("stray source event");
    a_event_single: assert property (event_req != '0 |=>
        (event_req & $past(event_req)) == '0)
        else $error("long event");
    a_clear_drops: assert property (
        acc && pwrite && paddr == ADDR_PEND
        && pwdata[NLINE-1:0] == '1 |=> !irq || event_req != '0)
        else $error("irq kept");
    a_irq_cause: assert property ($rose(irq) |-> event_req != '0)
        else $error("irq without edge");
    c_irq: cover property ($rose(irq));
    c_err: cover property (acc && pslverr);
    c_src: cover property (event_req[NLINE-1:NPINLINE] != '0);
endmodule

bind gei_top gei_monitor gei_monitor_inst (.*);

// File: dv/gei_pins.sv
// Model of the pads, peripherals and line sources around the port.
`timescale 1ns/1ps
module gei_pins
    import gei_pkg::*;
(
    // Clock
    input wire logic              pclk,
    // Pad side
    input wire gei_pad_type       pad,
    output logic [NPIN-1:0]       pad_in,
    // Peripherals and line sources
    output logic [NAF-1:0]        af_out,
    output logic [NAF-1:0]        af_oe,
    output logic [NEXT-1:0]       ext_pins,
    output logic [NSRC-1:0]       onchip_src
);
    logic [NPIN-1:0] float_r = 16'h5a5a;
    // A floating pad shows a pattern that changes every cycle, so that no
    // test can pass on a level the simulator picked for an unknown.
    always @(posedge pclk) float_r <= ~float_r;
    assign pad_in = (pad.oe & pad.out) | (~pad.oe & pad.pull_up)
        | (~pad.oe & ~pad.pull_up & ~pad.pull_down & float_r);
    initial begin
        af_out = '0;
        af_oe = '0;
        ext_pins = '0;
        onchip_src = '0;
    end
    // Index NEXT and above reaches the on-chip sources.
    task automatic step(input int idx, input logic v);
        #3;
        if (idx < NEXT) ext_pins[idx] = v;
        else onchip_src[idx-NEXT] = v;
    endtask
    // Pulse far narrower than one clock period.
    task automatic blip(input int idx);
        step(idx, 1'b1);
        #5;
        ext_pins[idx] = 1'b0;
    endtask
endmodule

// File: dv/gei_top_test.sv
// Self-checking testbench of the GPIO and edge interrupt block.
`timescale 1ns/1ps
module gei_top_test import gei_pkg::*;;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [11:0]       paddr, a;
    logic [31:0]       pwdata, prdata, d, r, pv;
    logic              e;
    gei_pad_type       pad;
    logic [NPIN-1:0]   pad_in, af_in, pm;
    logic [NAF-1:0]    af_out, af_oe;
    logic [REMAPW-1:0] sys_remap;
    logic [NTIM-1:0]   tim_capture;
    logic [NEXT-1:0]   ext_pins;
    logic [NSRC-1:0]   onchip_src;
    logic [NLINE-1:0]  event_req;
    int mismatches = 0, total_checks = 0, m, k;
    integer seed = 32'h4d34;
    always #10 pclk = ~pclk;
    gei_top gei_top_inst (.*);
    gei_pins gei_pins_inst (.*);
    // ----------------
    // Tasks and functions
    // ----------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [63:0] x, g);
        total_checks++;
        if (g !== x) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, x, g);
        end
    endtask
    // Requests change only after an edge and stay until ready is seen.
    task automatic apb(input logic w, input logic [11:0] ad,
                       input logic [31:0] wd);
        int n;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, wd};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
        apb(1'b1, ad, wd);
    endtask
    task automatic rd(input logic [11:0] ad, input logic [31:0] x);
        apb(1'b0, ad, 32'h0);
        chk($sformatf("read %h", ad), x, r);
    endtask
    function automatic logic [15:0] pull_mask(logic [31:0] f, logic [1:0] c);
        for (int i = 0; i < NPIN; i++) pull_mask[i] = (f[2*i +: 2] == c);
    endfunction
    initial begin
        #1_000_000;
        mismatches++;
        close_out();
    end
    // ----------------
    // Main sequence
    // ----------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (a = 12'h000; a <= 12'h04c; a += 12'h004) begin
            if (a != ADDR_IDATA) rd(a, RST_ZERO);
        end
        chk("pads", 64'h0, pad);
        apb(1'b0, 12'h050, 32'h0);
        chk("err", 2'h2, {e, |r});
        apb(1'b0, 12'h006, 32'h0);
        chk("err", 2'h2, {e, |r});
        d = $random(seed);
        wr(ADDR_DIR, 32'hffff);
        wr(ADDR_ODATA, {16'h0, d[15:0]});
        repeat (4) @(posedge pclk);
        chk("out", {16'hffff, d[15:0]}, {pad.oe, pad.out});
        chk("af_in", d[15:0], af_in);
        rd(ADDR_IDATA, {16'h0, d[15:0]});
        wr(ADDR_OTYPE, 32'hffff);
        repeat (2) @(posedge pclk);
        chk("drain", {16'h0, ~d[15:0]}, pad.oe);
        wr(ADDR_DIR, 32'h0);
        wr(ADDR_OTYPE, 32'h0);
        pv = $random(seed) & 32'h5555_5555;
        pv[31:30] = PULL_DOWN;
        wr(ADDR_PULL, pv);
        repeat (4) @(posedge pclk);
        chk("pull up", pull_mask(pv, PULL_UP), pad.pull_up);
        chk("pull dn", pull_mask(pv, PULL_DOWN), pad.pull_down);
        pm = pull_mask(pv, PULL_UP) | pull_mask(pv, PULL_DOWN);
        apb(1'b0, ADDR_IDATA, 32'h0);
        chk("pulled", pull_mask(pv, PULL_UP), r[15:0] & pm);
        gei_pins_inst.af_out = 4'h4;
        gei_pins_inst.af_oe = 4'h4;
        wr(ADDR_AFMAP, 32'h2);
        wr(ADDR_AFSEL, 32'h1);
        wr(ADDR_SYSREMAP, {24'h0, d[23:16]});
        wr(ADDR_TIMSEL, {20'h0, d[27:16]});
        repeat (2) @(posedge pclk);
        chk("alt", {2'h3, d[23:16]},
            {pad.oe[0], pad.out[0], sys_remap});
        wr(ADDR_LOCK, LOCK_KEY1);
        wr(ADDR_LOCK, 32'h1234);
        rd(ADDR_LOCK, 32'h0);
        wr(ADDR_LOCK, LOCK_KEY1);
        wr(ADDR_LOCK, LOCK_KEY2);
        rd(ADDR_LOCK, 32'h1);
        wr(ADDR_AFSEL, 32'hffff);
        wr(ADDR_TIMSEL, 32'h0);
        wr(ADDR_DIR, 32'h00f0);
        rd(ADDR_AFSEL, 32'h1);
        rd(ADDR_TIMSEL, {20'h0, d[27:16]});
        rd(ADDR_DIR, 32'h00f0);
        wr(ADDR_LINESEL, NEXT - 1);
        wr(ADDR_IMASK, 32'h00ff_ffff);
        wr(ADDR_EMASK, 32'h00ff_ffff);
        for (m = 1; m <= 3; m++) begin
            wr(ADDR_RISE, m[0] ? 32'h00ff_ffff : 32'h0);
            wr(ADDR_FALL, m[1] ? 32'h00ff_ffff : 32'h0);
            gei_pins_inst.step(NEXT - 1, 1'b1);
            repeat (6) @(posedge pclk);
            chk("irq", m[0], irq);
            rd(ADDR_PEND, m[0]);
            wr(ADDR_PEND, 32'h00ff_ffff);
            @(posedge pclk);
            chk("irq", 1'b0, irq);
            gei_pins_inst.step(NEXT - 1, 1'b0);
            repeat (6) @(posedge pclk);
            wr(ADDR_PEND, 32'h0);
            rd(ADDR_PEND, m[1]);
            wr(ADDR_PEND, 32'h00ff_ffff);
        end
        wr(ADDR_FALL, 32'h0);
        gei_pins_inst.blip(NEXT - 1);
        repeat (6) @(posedge pclk);
        rd(ADDR_PEND, 32'h1);
        wr(ADDR_PEND, 32'h00ff_ffff);
        wr(ADDR_IMASK, 32'h00ff_fffe);
        k = 1 + $unsigned($random(seed)) % (NEXT - 1);
        wr(ADDR_LINESEL + 12'h004, k << 8);
        gei_pins_inst.blip(NEXT - 1);
        gei_pins_inst.step(k, 1'b1);
        repeat (6) @(posedge pclk);
        rd(ADDR_PEND, 32'h20);
        wr(ADDR_PEND, 32'h00ff_ffff);
        k = $unsigned($random(seed)) % NSRC;
        gei_pins_inst.step(NEXT + k, 1'b1);
        repeat (6) @(posedge pclk);
        chk("irq", 1'b1, irq);
        rd(ADDR_PEND, 32'h1 << (NPINLINE + k));
        close_out();
    end
endmodule
